// ==== bench/led_observer.sv ====
`timescale 1ns/10ps
`default_nettype none
// far side: eight leds, each seen as a duty meter over fixed 100-cycle windows
module led_observer #(
  parameter int N = 8
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [N-1:0] led_pwm,
  output logic [7:0] duty [N],
  output logic [7:0] peaks [N]
);
  logic [6:0] slot;
  logic [7:0] cnt [N];
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      slot <= 7'h00;
      for (int i = 0; i < N; i++) begin
        cnt[i] <= 8'h00;
        duty[i] <= 8'h00;
        peaks[i] <= 8'h00;
      end
    end else begin
      slot <= (slot == 7'd99) ? 7'h00 : slot + 7'h01;
      for (int i = 0; i < N; i++) begin
        if (slot == 7'd99) begin
          cnt[i] <= 8'h00;
          duty[i] <= cnt[i] + 8'(led_pwm[i]);
          // a peak is entry into a full-on window; window phase is free, so a
          // top step must last over a frame to be seen
          if (cnt[i] + 8'(led_pwm[i]) == 8'd100 && duty[i] != 8'd100) begin
            peaks[i] <= peaks[i] + 8'h01;
          end
        end else begin
          cnt[i] <= cnt[i] + 8'(led_pwm[i]);
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic mclk, reset_n, read, write, waitrequest, alert_n;
  logic [7:0] address, led_pwm, touch;
  logic [31:0] writedata, readdata, q;
  logic [15:0] sel;
  logic [7:0] duty [8];
  logic [7:0] peaks [8];
  int err_count = 0;
  int check_count = 0;
  byte unsigned maxp [16] = '{7, 9, 11, 14, 17, 20, 23, 26, 30, 35, 40, 46, 53, 63, 77, 100};
  byte unsigned minp [16] = '{0, 7, 9, 11, 14, 17, 20, 23, 26, 30, 35, 40, 46, 53, 63, 77};
  led_breathe_pulse_timing #(.STEP_CYCLES(3200), .NUM_LEDS(8)) led_breathe_pulse_timing_i (
    .mclk(mclk), .reset_n(reset_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .led_behavior_select(sel), .touch_actuate(touch), .led_pwm(led_pwm), .alert_n(alert_n));
  led_observer #(.N(8)) led_observer_i (.mclk(mclk), .reset_n(reset_n), .led_pwm(led_pwm),
    .duty(duty), .peaks(peaks));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic finish_test;
    if (err_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", n, e, g);
    end
  endtask
  // request held until waitrequest is sampled low; readdata taken at that edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n = 0;
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= {24'h000000, d};
    @(posedge mclk);
    while (waitrequest !== 1'b0 && n < 1000) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 1000) err_count++;
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h00);
    chk(n, e, q);
  endtask
  task automatic test_resets;
    logic [7:0] adr [8] = '{8'h85, 8'h86, 8'h88, 8'h90, 8'h91, 8'h92, 8'h93, 8'h87};
    logic [7:0] val [8] = '{8'h14, 8'h5D, 8'h04, 8'hF0, 8'hF0, 8'hF0, 8'hF0, 8'h00};
    for (int i = 0; i < 8; i++) rd_chk("reset value", adr[i], 32'(val[i]));
  endtask
  task automatic test_fields;
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, (i == 2) ? 8'h88 : 8'h85 + 8'(i), 8'hFF);
      rd_chk("top bit", (i == 2) ? 8'h88 : 8'h85 + 8'(i), 32'h0000007F);
    end
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 8'h90 + 8'(i), 8'hA5 + 8'(i));
      rd_chk("duty pair", 8'h90 + 8'(i), 32'(8'hA5 + 8'(i)));
    end
    bus(1'b1, 8'h87, 8'h5A);
    rd_chk("unmapped", 8'h87, 32'h00000000);
    bus(1'b1, 8'h85, 8'h05);
    bus(1'b1, 8'h91, 8'hF0);
    bus(1'b1, 8'h88, 8'h00);
  endtask
  // led0 direct and on, led1 direct and off; new limits must show without re-actuation
  task automatic test_duty;
    bus(1'b1, 8'hA0, 8'h01);
    for (int c = 0; c < 16; c++) begin
      bus(1'b1, 8'h93, {4'(c), 4'(c)});
      repeat (250) @(posedge mclk);
      chk("upper duty", 32'(maxp[c]), 32'(duty[0]));
      chk("lower duty", 32'(minp[c]), 32'(duty[1]));
    end
    bus(1'b1, 8'hA0, 8'h00);
  endtask
  task automatic test_pulse_alert;
    int n = 0;
    bus(1'b1, 8'h88, 8'h50);
    bus(1'b1, 8'hA0, 8'h04);
    bus(1'b1, 8'hA0, 8'h00);
    while (alert_n !== 1'b0 && n < 80000) begin
      @(posedge mclk);
      n++;
    end
    chk("alert_n", 32'h0, 32'(alert_n));
    chk("pulse count", 32'h3, 32'(peaks[2]));
    rd_chk("status", 8'hA1, 32'h00000004);
    bus(1'b1, 8'hA1, 8'h04);
    repeat (3) @(posedge mclk);
    chk("alert_n cleared", 32'h1, 32'(alert_n));
  endtask
  // touch-started pattern runs its one pulse but must never pull the alert
  task automatic test_touch;
    int lows = 0;
    bus(1'b1, 8'h88, 8'h40);
    bus(1'b1, 8'h90, 8'hF0);
    touch <= 8'h18;
    repeat (3) @(posedge mclk);
    touch <= 8'h00;
    repeat (25000) begin
      @(posedge mclk);
      if (alert_n !== 1'b1) lows++;
    end
    chk("touch alert", 32'h0, 32'(lows));
    chk("touch pulses", 32'h1, 32'(peaks[3]));
    chk("first pattern pulses", 32'h1, 32'(peaks[4]));
  endtask
  initial begin
    repeat (95000) @(posedge mclk);
    err_count++;
    finish_test;
  end
  initial begin
    reset_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    writedata = 32'h00000000;
    sel = 16'h01A0;
    touch = 8'h00;
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    test_resets;
    test_fields;
    test_duty;
    test_pulse_alert;
    test_touch;
    finish_test;
  end
endmodule
`default_nettype wire

// ==== hw/led_breathe_pulse_timing.sv ====
// Contract
// - second pulse period counts 32 ms per code, reset code gives 640 ms.
// - breathe period counts 32 ms per code, reset gives 2976 ms.
// - seven-bit periods span 32 ms to 4.064 s; bit 7 unused.
// - periods below 160 ms run at shortest achievable period; codes 1 to 4 run at their own 32 to 128 ms, only code 0 is raised to 1.
// - second pulse period used only by behaviour code 10b.
// - breathe period governs behaviour code 11b.
// - finish-alert enable bit 6 raises active-low alert on software-started completions.
// - touch-started activity never raises completion alert.
// - pulse count fields give code plus one pulses.
// - pulse configuration register resets to 04h.
// - separate duty limit pairs per behaviour at 90h to 93h.
// - duty ramps from minimum up to maximum then back to minimum.
// - maximum duty code decodes 7 to 100 percent.
// - minimum duty code decodes 0 to 77 percent.
// - direct behaviour applies new duty settings at once.
// - pattern behaviours ignore setting changes until re-actuated.
// - second pulse repeats while started, finishes count on stop, settles minimum.
// - breathe rise and fall each take half the period.
//
// Implementation choice: the Avalon-MM register port.
`include "led_timing_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module led_breathe_pulse_timing #(
  parameter int STEP_CYCLES = `STEP_CYCLES,
  parameter int NUM_LEDS = 8
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [2*NUM_LEDS-1:0] led_behavior_select,
  input wire logic [NUM_LEDS-1:0] touch_actuate,
  output logic [NUM_LEDS-1:0] led_pwm,
  output logic alert_n
);
  localparam int LW = 2 * `STEPS_PER_RAMP;
  logic [6:0] second_pulse_period_reg;
  logic [6:0] breathe_period_reg;
  logic [6:0] pulse_count_config_reg;
  led_timing_pkg::duty_pair_t duty_reg [4];
  logic [NUM_LEDS-1:0] output_control_reg;
  logic [NUM_LEDS-1:0] done_reg;
  logic alert_reg;
  logic ack_reg;
  logic [7:0] pwm_cnt_reg;
  logic [31:0] base_cnt_reg;
  logic base_tick;
  led_timing_pkg::av_req_t req;
  logic [NUM_LEDS-1:0] done_evt;
  logic [NUM_LEDS-1:0] sw_evt;

  assign req = '{address: address, read: read, write: write, writedata: writedata};

  // maximum duty decode in percent
  function automatic logic [7:0] upper_pct(input logic [3:0] c);
    case (c)
      4'h0: upper_pct = 8'h07;
      4'h1: upper_pct = 8'h09;
      4'h2: upper_pct = 8'h0B;
      4'h3: upper_pct = 8'h0E;
      4'h4: upper_pct = 8'h11;
      4'h5: upper_pct = 8'h14;
      4'h6: upper_pct = 8'h17;
      4'h7: upper_pct = 8'h1A;
      4'h8: upper_pct = 8'h1E;
      4'h9: upper_pct = 8'h23;
      4'hA: upper_pct = 8'h28;
      4'hB: upper_pct = 8'h2E;
      4'hC: upper_pct = 8'h35;
      4'hD: upper_pct = 8'h3F;
      4'hE: upper_pct = 8'h4D;
      default: upper_pct = 8'h64;
    endcase
  endfunction

  // the minimum table is the maximum table shifted one code down
  function automatic logic [7:0] lower_pct(input logic [3:0] c);
    lower_pct = (c == 4'h0) ? 8'h00 : upper_pct(c - 4'h1);
  endfunction

  // writes finish at once; reads take one wait state so that readdata is
  // already registered when the master samples waitrequest low
  assign waitrequest = req.read & ~ack_reg;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req.read & ~ack_reg;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      second_pulse_period_reg <= `RST_SECOND_PULSE_PERIOD;
      breathe_period_reg <= `RST_BREATHE_PERIOD;
      pulse_count_config_reg <= `RST_PULSE_COUNT_CONFIG;
      for (int i = 0; i < 4; i++) begin
        duty_reg[i] <= `RST_DUTY_LIMITS;
      end
      output_control_reg <= '0;
    end else if (req.write) begin
      // bit 7 of the period and pulse configuration registers is dropped
      case (req.address)
        `OFS_SECOND_PULSE_PERIOD: second_pulse_period_reg <= req.writedata[6:0];
        `OFS_BREATHE_PERIOD: breathe_period_reg <= req.writedata[6:0];
        `OFS_PULSE_COUNT_CONFIG: pulse_count_config_reg <= req.writedata[6:0];
        `OFS_FIRST_PULSE_DUTY: duty_reg[0] <= req.writedata[7:0];
        `OFS_SECOND_PULSE_DUTY: duty_reg[1] <= req.writedata[7:0];
        `OFS_BREATHE_DUTY: duty_reg[2] <= req.writedata[7:0];
        `OFS_DIRECT_DUTY: duty_reg[3] <= req.writedata[7:0];
        `OFS_LED_CONTROL: output_control_reg <= req.writedata[NUM_LEDS-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      readdata <= '0;
    end else if (req.read) begin
      case (req.address)
        `OFS_SECOND_PULSE_PERIOD: readdata <= {25'h0, second_pulse_period_reg};
        `OFS_BREATHE_PERIOD: readdata <= {25'h0, breathe_period_reg};
        `OFS_PULSE_COUNT_CONFIG: readdata <= {25'h0, pulse_count_config_reg};
        `OFS_FIRST_PULSE_DUTY: readdata <= {24'h0, duty_reg[0]};
        `OFS_SECOND_PULSE_DUTY: readdata <= {24'h0, duty_reg[1]};
        `OFS_BREATHE_DUTY: readdata <= {24'h0, duty_reg[2]};
        `OFS_DIRECT_DUTY: readdata <= {24'h0, duty_reg[3]};
        `OFS_LED_CONTROL: readdata <= {{(32-NUM_LEDS){1'b0}}, output_control_reg};
        `OFS_LED_STATUS: readdata <= {{(32-NUM_LEDS){1'b0}}, done_reg};
        default: readdata <= '0;
      endcase
    end
  end

  // fixed 1 ms tick; a ramp step lasts one tick per period code unit
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      base_cnt_reg <= '0;
    end else if (base_tick) begin
      base_cnt_reg <= '0;
    end else begin
      base_cnt_reg <= base_cnt_reg + 32'h1;
    end
  end
  // 32 ms / 32 ramp steps = 1 ms per step per code unit
  assign base_tick = (base_cnt_reg >= 32'(STEP_CYCLES / LW - 1));

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pwm_cnt_reg <= '0;
    end else if (pwm_cnt_reg == `PWM_PERIOD - 8'h1) begin
      pwm_cnt_reg <= '0;
    end else begin
      pwm_cnt_reg <= pwm_cnt_reg + 8'h1;
    end
  end

  for (genvar g = 0; g < NUM_LEDS; g++) begin : led_gen
    led_timing_pkg::led_state_t state_reg;
    led_timing_pkg::behavior_t beh;
    led_timing_pkg::behavior_t beh_reg;
    logic [3:0] up_reg, lo_reg;
    logic [6:0] per_reg;
    logic [2:0] cnt_reg;
    logic [2:0] pulses_reg;
    logic [4:0] step_reg;
    logic [6:0] div_reg;
    logic act, act_d_reg, sw_reg;
    logic [7:0] duty_lo, duty_hi, duty_now;
    logic [12:0] span;
    assign beh = led_timing_pkg::behavior_t'(led_behavior_select[2*g+1:2*g]);
    assign act = output_control_reg[g] | touch_actuate[g];
    assign duty_lo = lower_pct(beh_reg == led_timing_pkg::BEH_DIRECT ? duty_reg[3].lower : lo_reg);
    assign duty_hi = upper_pct(beh_reg == led_timing_pkg::BEH_DIRECT ? duty_reg[3].upper : up_reg);
    // even spread of duty between limits across ramp steps
    assign span = 13'(duty_hi > duty_lo ? duty_hi - duty_lo : 8'h0) * 13'(step_reg);
    assign duty_now = (state_reg == led_timing_pkg::ST_RISE || state_reg ==
      led_timing_pkg::ST_FALL) ? 8'(duty_lo + 8'(span / 13'(`STEPS_PER_RAMP - 1))) :
      (state_reg == led_timing_pkg::ST_HOLD) ? duty_hi : duty_lo;
    assign done_evt[g] = (state_reg == led_timing_pkg::ST_FALL) && base_tick &&
      div_reg == 7'h0 && step_reg == 5'h0 && cnt_reg == 3'h0 &&
      (beh_reg != led_timing_pkg::BEH_SECOND_PULSE || !act);
    assign sw_evt[g] = done_evt[g] & sw_reg;

    always_ff @(posedge mclk) begin
      if (!reset_n) begin
        act_d_reg <= 1'b0;
      end else begin
        act_d_reg <= act;
      end
    end

    always_ff @(posedge mclk) begin
      if (!reset_n) begin
        state_reg <= led_timing_pkg::ST_IDLE;
        beh_reg <= led_timing_pkg::BEH_DIRECT;
        up_reg <= '0;
        lo_reg <= '0;
        per_reg <= '0;
        cnt_reg <= '0;
        step_reg <= '0;
        div_reg <= '0;
        sw_reg <= 1'b0;
      end else begin
        case (state_reg)
          led_timing_pkg::ST_IDLE: begin
            if (act && !act_d_reg) begin
              // settings latched only at actuation
              beh_reg <= beh;
              sw_reg <= output_control_reg[g] & ~touch_actuate[g];
              step_reg <= '0;
              div_reg <= '0;
              case (beh)
                led_timing_pkg::BEH_FIRST_PULSE: begin
                  {up_reg, lo_reg} <= duty_reg[0];
                  per_reg <= 7'h0;
                  cnt_reg <= pulse_count_config_reg[2:0];
                  state_reg <= led_timing_pkg::ST_RISE;
                end
                led_timing_pkg::BEH_SECOND_PULSE: begin
                  {up_reg, lo_reg} <= duty_reg[1];
                  per_reg <= second_pulse_period_reg;
                  cnt_reg <= pulse_count_config_reg[5:3];
                  state_reg <= led_timing_pkg::ST_RISE;
                end
                led_timing_pkg::BEH_BREATHE: begin
                  {up_reg, lo_reg} <= duty_reg[2];
                  per_reg <= breathe_period_reg;
                  cnt_reg <= 3'h0;
                  state_reg <= led_timing_pkg::ST_RISE;
                end
                default: state_reg <= led_timing_pkg::ST_HOLD;
              endcase
            end
          end
          led_timing_pkg::ST_RISE, led_timing_pkg::ST_FALL: begin
            if (beh_reg == led_timing_pkg::BEH_BREATHE && !act) begin
              state_reg <= led_timing_pkg::ST_IDLE;
            end else if (base_tick) begin
              // code 0 acts as 1; other short codes are used as given, with no minimum
              if (div_reg + 7'h1 < (per_reg == 7'h0 ? 7'h1 : per_reg)) begin
                div_reg <= div_reg + 7'h1;
              end else begin
                div_reg <= '0;
                if (state_reg == led_timing_pkg::ST_RISE) begin
                  if (step_reg == 5'(`STEPS_PER_RAMP - 1)) begin
                    state_reg <= led_timing_pkg::ST_FALL;
                  end else begin
                    step_reg <= step_reg + 5'h1;
                  end
                end else if (step_reg != 5'h0) begin
                  step_reg <= step_reg - 5'h1;
                end else if (beh_reg == led_timing_pkg::BEH_SECOND_PULSE && act) begin
                  state_reg <= led_timing_pkg::ST_RISE;
                end else if (cnt_reg != 3'h0) begin
                  cnt_reg <= cnt_reg - 3'h1;
                  state_reg <= led_timing_pkg::ST_RISE;
                end else if (beh_reg == led_timing_pkg::BEH_BREATHE) begin
                  state_reg <= led_timing_pkg::ST_RISE;
                end else begin
                  state_reg <= led_timing_pkg::ST_IDLE;
                end
              end
            end
          end
          led_timing_pkg::ST_HOLD: begin
            if (!act) begin
              state_reg <= led_timing_pkg::ST_IDLE;
            end
          end
          default: state_reg <= led_timing_pkg::ST_IDLE;
        endcase
      end
    end

    always_ff @(posedge mclk) begin
      if (!reset_n) begin
        led_pwm[g] <= 1'b0;
      end else begin
        led_pwm[g] <= (pwm_cnt_reg < duty_now);
      end
    end

    // only direct leds park at the live upper limit
    hold_direct_a: assert property (@(posedge mclk) disable iff (!reset_n)
      state_reg == led_timing_pkg::ST_HOLD |-> beh_reg == led_timing_pkg::BEH_DIRECT)
      else $error("hold state outside direct behaviour");

    // a running pattern must not pick up register writes
    latch_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
      state_reg != led_timing_pkg::ST_IDLE |=>
      $stable(up_reg) && $stable(lo_reg) && $stable(per_reg))
      else $error("pattern settings changed while running");

    duty_range_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (state_reg == led_timing_pkg::ST_RISE || state_reg == led_timing_pkg::ST_FALL) |->
      duty_now >= duty_lo && (duty_hi < duty_lo || duty_now <= duty_hi))
      else $error("ramp duty outside limits");

    step_limit_a: assert property (@(posedge mclk) disable iff (!reset_n)
      step_reg < 5'(`STEPS_PER_RAMP))
      else $error("ramp step out of range");
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      done_reg <= '0;
    end else begin
      // set wins over a clear by write
      done_reg <= (done_reg & ~((req.write && req.address == `OFS_LED_STATUS) ?
        req.writedata[NUM_LEDS-1:0] : '0)) | sw_evt;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      alert_reg <= 1'b0;
    end else begin
      alert_reg <= pulse_count_config_reg[`FINISH_ALERT_BIT] && (done_reg != '0);
    end
  end
  assign alert_n = ~alert_reg;

  alert_gate_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !pulse_count_config_reg[`FINISH_ALERT_BIT] |=> alert_n)
    else $error("alert raised while disabled");

  alert_follow_a: assert property (@(posedge mclk) disable iff (!reset_n)
    pulse_count_config_reg[`FINISH_ALERT_BIT] && done_reg != '0 |=> !alert_n)
    else $error("alert missing for finished pattern");

  cfg_bit7_a: assert property (@(posedge mclk) disable iff (!reset_n)
    read && address == `OFS_BREATHE_PERIOD |=> readdata[7] == 1'b0)
    else $error("unused bit read nonzero");

  period_bits_a: assert property (@(posedge mclk) disable iff (!reset_n)
    read && address == `OFS_SECOND_PULSE_PERIOD |=> readdata[31:7] == '0)
    else $error("period wider than seven bits");

  // touch-only completions must leave the sticky status alone
  touch_no_alert_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (done_evt & ~sw_evt) != '0 && sw_evt == '0 && done_reg == '0 |=> done_reg == '0)
    else $error("touch activity flagged completion");

  // set wins over a same-cycle clear
  status_set_a: assert property (@(posedge mclk) disable iff (!reset_n)
    sw_evt != '0 |=> (done_reg & $past(sw_evt)) == $past(sw_evt))
    else $error("completion status lost");

  tick_bound_a: assert property (@(posedge mclk) disable iff (!reset_n)
    base_cnt_reg < 32'(STEP_CYCLES / LW))
    else $error("tick divider overran");

  pwm_bound_a: assert property (@(posedge mclk) disable iff (!reset_n)
    pwm_cnt_reg < `PWM_PERIOD)
    else $error("pwm frame counter overran");

  answer_one_a: assert property (@(posedge mclk) disable iff (!reset_n)
    write |-> !waitrequest)
    else $error("write not answered at once");

  read_wait_a: assert property (@(posedge mclk) disable iff (!reset_n)
    read && waitrequest |=> !read || !waitrequest)
    else $error("read held in wait too long");
endmodule
`default_nettype wire

// ==== hw/led_timing_cfg.svh ====
`ifndef LED_TIMING_CFG_SVH
`define LED_TIMING_CFG_SVH
`define OFS_SECOND_PULSE_PERIOD 8'h85
`define OFS_BREATHE_PERIOD 8'h86
`define OFS_PULSE_COUNT_CONFIG 8'h88
`define OFS_FIRST_PULSE_DUTY 8'h90
`define OFS_SECOND_PULSE_DUTY 8'h91
`define OFS_BREATHE_DUTY 8'h92
`define OFS_DIRECT_DUTY 8'h93
`define OFS_LED_CONTROL 8'hA0
`define OFS_LED_STATUS 8'hA1
`define RST_SECOND_PULSE_PERIOD 7'h14
`define RST_BREATHE_PERIOD 7'h5D
`define RST_PULSE_COUNT_CONFIG 7'h04
`define RST_DUTY_LIMITS 8'hF0
`define FINISH_ALERT_BIT 6
`define PERIOD_STEP_MS 32
`define MIN_PERIOD_CODE 7'h05
`define CLOCK_MHZ 100
`define STEP_CYCLES (`PERIOD_STEP_MS * 1000 * `CLOCK_MHZ)
`define STEPS_PER_RAMP 16
`define PWM_PERIOD 8'h64
`endif

// ==== hw/led_timing_pkg.sv ====
package led_timing_pkg;
  typedef enum logic [1:0] {
    BEH_DIRECT = 2'h0,
    BEH_FIRST_PULSE = 2'h1,
    BEH_SECOND_PULSE = 2'h2,
    BEH_BREATHE = 2'h3
  } behavior_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_RISE = 4'h2,
    ST_FALL = 4'h4,
    ST_HOLD = 4'h8
  } led_state_t;
  typedef struct packed {
    logic [3:0] upper;
    logic [3:0] lower;
  } duty_pair_t;
  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } av_req_t;
endpackage
